// [src/tmc_pkg.sv]
package tmc_pkg;

   // Mode field encodings
   localparam logic [2:0] MODE_SLEEP = 3'h0;
   localparam logic [2:0] MODE_STDBY = 3'h1;
   localparam logic [2:0] MODE_FS_TX = 3'h2;
   localparam logic [2:0] MODE_TX = 3'h3;
   localparam logic [2:0] MODE_FS_RX = 3'h4;
   localparam logic [2:0] MODE_RX = 3'h5;

   // Receive trigger encodings
   localparam logic [2:0] TRIG_NONE = 3'h0;
   localparam logic [2:0] TRIG_RSSI = 3'h1;
   localparam logic [2:0] TRIG_PREAMBLE = 3'h6;
   localparam logic [2:0] TRIG_BOTH = 3'h7;

   localparam logic [1:0] AUTO_RESTART_OFF = 2'h0;
   localparam logic [1:0] AUTO_RESTART_SAME = 2'h1;

   // Clock and timing
   localparam int CLK_MHZ = 40;
   localparam int TX_FIXED_NS = 5000;
   localparam int TX_FIXED_CYC = (TX_FIXED_NS * CLK_MHZ + 999) / 1000;
   // Ramp scale 1.25 expressed as 5/4
   localparam int RAMP_NUM = 5;
   localparam int RAMP_DEN = 4;
   // Countdown loaded for each unstretched wake-up step; the step lasts one cycle more than this
   localparam int STEP_CYC = 4;
   localparam int BW_ENTRIES = 21;

   // Receiver startup delays per bandwidth index, in microseconds
   localparam int RX_DELAY_US [BW_ENTRIES] = '{
      2330, 1940, 1560, 1180, 984, 791, 601, 504, 407, 313, 264,
      215, 169, 144, 119, 97, 84, 71, 85, 74, 63};

   localparam logic [3:0] BLK_RESET = 4'h0;
   localparam logic [3:0] BLK_ALL_OFF = 4'h0;

   // Enabled-block vector
   typedef struct packed {
      logic regulator;
      logic oscillator;
      logic synth;
      logic rf_path;
   } tmc_blocks_t;

   // Receiver configuration
   typedef struct packed {
      logic agc_on;
      logic afc_on;
      logic [2:0] trigger;
      logic [4:0] rx_bw;
      logic [4:0] afc_bw;
      logic [2:0] lna_gain;
      logic [1:0] auto_restart;
   } tmc_rx_cfg_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REG = 3'b001,
      ST_OSC = 3'b011,
      ST_SYN = 3'b010,
      ST_RF = 3'b110,
      ST_WAIT = 3'b111,
      ST_READY = 3'b101
   } tmc_state_t;

endpackage

// [src/tmc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Data
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta_r;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_r <= '0;
         o_sync <= '0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // tmc_sync
`default_nettype wire

// [src/tmc_delay_calc.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_delay_calc
   import tmc_pkg::*;
#(
   parameter int CW = 24
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Settings
   input wire logic i_ook,
   input wire logic [15:0] i_ramp_us,
   input wire logic [15:0] i_bit_cyc,
   input wire logic [4:0] i_bw_idx,
   // Results in clock cycles
   output logic [CW-1:0] o_tx_cyc,
   output logic [CW-1:0] o_rx_cyc
);
   function automatic logic [CW-1:0] us_to_cyc(input int us);
      return CW'(us * CLK_MHZ);
   endfunction

   logic [CW-1:0] ramp_cyc;
   logic [CW-1:0] tx_nxt;
   logic [CW-1:0] rx_nxt;

   // Ramp term rounded up so the ready point is never early
   assign ramp_cyc = CW'(((32'(i_ramp_us) * CLK_MHZ * RAMP_NUM) + RAMP_DEN - 1) / RAMP_DEN);
   assign tx_nxt = CW'(TX_FIXED_CYC) + (i_ook ? CW'(0) : ramp_cyc) + CW'(i_bit_cyc >> 1);
   // Out-of-range index takes the slowest entry
   assign rx_nxt = (i_bw_idx < 5'(BW_ENTRIES)) ? us_to_cyc(RX_DELAY_US[i_bw_idx]) : us_to_cyc(RX_DELAY_US[0]);

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tx_cyc <= '0;
         o_rx_cyc <= '0;
      end else begin
         o_tx_cyc <= tx_nxt;
         o_rx_cyc <= rx_nxt;
      end
   end
endmodule // tmc_delay_calc
`default_nettype wire

// [src/tmc_mode_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_mode_ctrl
   import tmc_pkg::*;
#(
   parameter int CW = 24,
   parameter int RELOCK_CYC = 8000,
   parameter int GAP_W = 16
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Mode, transmit and receive settings
   input wire logic [2:0] i_operating_mode_register,
   input wire logic i_ook,
   input wire logic [15:0] i_amplifier_ramp_time,
   input wire logic [15:0] i_bit_cyc,
   input wire logic [15:0] i_signal_strength_eval_delay,
   input wire tmc_pkg::tmc_rx_cfg_t i_rx_cfg,
   input wire logic [GAP_W-1:0] i_inter_packet_cyc,
   // Restart trigger writes (one-cycle write strobes)
   input wire logic i_restart_keep_oscillator_wr,
   input wire logic i_restart_relock_oscillator_wr,
   // Receive events from pins
   input wire logic i_rssi_event_pin,
   input wire logic i_preamble_found_flag_pin,
   input wire logic i_payload_ready_pin,
   input wire logic i_fifo_empty_pin,
   // Status and control
   output tmc_pkg::tmc_blocks_t o_blocks,
   output logic o_mode_ready_flag,
   output logic o_tx_ready,
   output logic o_rx_ready,
   output logic o_rssi_valid,
   output logic o_restart_keep_oscillator,
   output logic o_restart_relock_oscillator,
   output logic o_agc_run,
   output logic o_afc_run,
   output logic [2:0] o_low_noise_amp_gain,
   output logic o_timeout_rssi_en,
   output logic o_timeout_preamble_en,
   output logic o_timeout_sync_en
);
   tmc_state_t state_r, state_nxt;
   logic [2:0] mode_r;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [CW-1:0] tx_cyc, rx_cyc;
   logic [15:0] rssi_cnt_r;
   logic keep_r, relock_r, relock_pend_r;
   logic rx_armed_r, rssi_valid_r, agc_r, afc_r;
   logic wait_empty_r, gap_run_r;
   logic [GAP_W-1:0] gap_r;
   logic [3:0] ev_s;
   logic rssi_ev, pre_ev, payload_ev, fifo_empty;
   logic mode_change, is_rx, is_tx, user_restart, auto_restart, restart;
   logic [4:0] bw_sel;
   logic trig_rssi, trig_pre, corr_start, gap_done;
   logic [CW-1:0] settle_cyc;
   logic restart_ok, keep_nxt, relock_nxt;
   logic osc_stage, syn_stage, rf_stage;

   tmc_sync #(
      .W(4)
   ) u_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_rssi_event_pin, i_preamble_found_flag_pin, i_payload_ready_pin, i_fifo_empty_pin}),
      .o_sync(ev_s)
   );
   assign rssi_ev = ev_s[3];
   assign pre_ev = ev_s[2];
   assign payload_ev = ev_s[1];
   assign fifo_empty = ev_s[0];

   assign bw_sel = i_rx_cfg.afc_on ? i_rx_cfg.afc_bw : i_rx_cfg.rx_bw;

   tmc_delay_calc #(
      .CW(CW)
   ) u_calc (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_ook(i_ook),
      .i_ramp_us(i_amplifier_ramp_time),
      .i_bit_cyc(i_bit_cyc),
      .i_bw_idx(bw_sel),
      .o_tx_cyc(tx_cyc),
      .o_rx_cyc(rx_cyc)
   );

   // Unknown codes 110/111 are held as standby
   function automatic tmc_blocks_t decode_mode(input logic [2:0] m);
      tmc_blocks_t b;
      b = '{default: 1'b0};
      case (m)
         MODE_SLEEP: b = '{default: 1'b0};
         MODE_STDBY: b = '{regulator: 1'b1, oscillator: 1'b1, synth: 1'b0, rf_path: 1'b0};
         MODE_FS_TX, MODE_FS_RX: b = '{regulator: 1'b1, oscillator: 1'b1, synth: 1'b1, rf_path: 1'b0};
         MODE_TX, MODE_RX: b = '{default: 1'b1};
         default: b = '{regulator: 1'b1, oscillator: 1'b1, synth: 1'b0, rf_path: 1'b0};
      endcase
      return b;
   endfunction

   tmc_blocks_t want, want_in;
   assign want = decode_mode(mode_r);
   assign want_in = decode_mode(i_operating_mode_register);
   assign mode_change = i_operating_mode_register != mode_r;
   assign is_rx = mode_r == MODE_RX;
   assign is_tx = mode_r == MODE_TX;

   // Restart taken only in receive with ready flag high; a mode write in the same cycle wins
   assign restart_ok = is_rx && o_mode_ready_flag && !mode_change;
   assign user_restart = restart_ok && (keep_r || relock_r);
   assign gap_done = gap_run_r && (gap_r == '0);
   assign auto_restart = restart_ok && gap_done;
   assign restart = user_restart || auto_restart;

   // A bit written while restart is refused falls away rather than firing later
   assign keep_nxt = i_restart_keep_oscillator_wr || (keep_r && !restart && restart_ok);
   assign relock_nxt = i_restart_relock_oscillator_wr || (relock_r && !restart && restart_ok);

   assign trig_rssi = (i_rx_cfg.trigger == TRIG_RSSI) || (i_rx_cfg.trigger == TRIG_BOTH);
   assign trig_pre = (i_rx_cfg.trigger == TRIG_PREAMBLE) || (i_rx_cfg.trigger == TRIG_BOTH);
   assign corr_start = rx_armed_r && ((trig_rssi && rssi_ev) || (trig_pre && pre_ev));

   // Non-radio modes never reach the settle step; one cycle keeps the counter harmless
   assign settle_cyc = is_tx ? tx_cyc : (is_rx ? rx_cyc : CW'(1));

   // A block is enabled only once the sequence has reached its step
   assign osc_stage = state_r inside {ST_OSC, ST_SYN, ST_RF, ST_WAIT, ST_READY};
   assign syn_stage = state_r inside {ST_SYN, ST_RF, ST_WAIT, ST_READY};
   assign rf_stage = state_r inside {ST_RF, ST_WAIT, ST_READY};

   // Wake-up sequence: regulator, oscillator, synthesizer, RF path, then settle
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = (cnt_r == '0) ? '0 : cnt_r - CW'(1);
      case (state_r)
         ST_IDLE: state_nxt = ST_READY;
         ST_REG: if (cnt_r == '0) begin
            state_nxt = want.oscillator ? ST_OSC : ST_READY;
            cnt_nxt = CW'(STEP_CYC);
         end
         // Relock stretches the synthesizer step so the loop can settle on the new carrier
         ST_OSC: if (cnt_r == '0) begin
            state_nxt = want.synth ? ST_SYN : ST_READY;
            cnt_nxt = (want.synth && relock_pend_r) ? CW'(RELOCK_CYC) : CW'(STEP_CYC);
         end
         ST_SYN: if (cnt_r == '0) begin
            state_nxt = want.rf_path ? ST_RF : ST_READY;
            cnt_nxt = CW'(STEP_CYC);
         end
         ST_RF: if (cnt_r == '0) begin
            state_nxt = ST_WAIT;
            cnt_nxt = settle_cyc;
         end
         ST_WAIT: if (cnt_r == '0) begin
            state_nxt = ST_READY;
         end
         ST_READY: ;
         default: state_nxt = ST_IDLE;
      endcase
      if (mode_change) begin
         state_nxt = (want.regulator || want_in.regulator) ? ST_REG : ST_READY;
         cnt_nxt = CW'(STEP_CYC);
      end else if (restart) begin
         // Both restarts re-enter at the oscillator step; only relock restart stretches the synthesizer step
         state_nxt = ST_OSC;
         cnt_nxt = '0;
      end
   end

   // Host mode is sampled every cycle; its difference from mode_r is the one-cycle change event
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= ST_READY;
         mode_r <= MODE_STDBY;
         cnt_r <= '0;
         o_blocks <= BLK_RESET;
      end else begin
         state_r <= state_nxt;
         mode_r <= i_operating_mode_register;
         cnt_r <= cnt_nxt;
         // Blocks switch on one step at a time
         o_blocks.regulator <= want.regulator && (state_r != ST_IDLE);
         o_blocks.oscillator <= want.oscillator && osc_stage;
         o_blocks.synth <= want.synth && syn_stage;
         o_blocks.rf_path <= want.rf_path && rf_stage;
      end
   end

   // Ready falls in the very cycle a new mode is written, before the state moves
   assign o_mode_ready_flag = (state_r == ST_READY) && !mode_change;
   assign o_tx_ready = is_tx && o_mode_ready_flag;
   assign o_rx_ready = is_rx && o_mode_ready_flag;

   // Trigger bits: set on host write, cleared when restart begins; a new write wins
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         keep_r <= 1'b0;
         relock_r <= 1'b0;
         relock_pend_r <= 1'b0;
      end else begin
         keep_r <= keep_nxt;
         relock_r <= relock_nxt;
         if (mode_change)
            relock_pend_r <= 1'b1;
         else if (user_restart)
            relock_pend_r <= relock_r;
         else if (state_r == ST_READY)
            relock_pend_r <= 1'b0;
      end
   end
   assign o_restart_keep_oscillator = keep_r;
   assign o_restart_relock_oscillator = relock_r;

   // Correction runs once per receiver start or restart
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_armed_r <= 1'b0;
         agc_r <= 1'b0;
         afc_r <= 1'b0;
      end else begin
         if (!o_rx_ready) begin
            rx_armed_r <= 1'b1;
            agc_r <= 1'b0;
            afc_r <= 1'b0;
         end else if (corr_start) begin
            rx_armed_r <= 1'b0;
            agc_r <= i_rx_cfg.agc_on;
            afc_r <= i_rx_cfg.agc_on && i_rx_cfg.afc_on;
         end
      end
   end
   assign o_agc_run = agc_r;
   assign o_afc_run = afc_r;

   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b)
         o_low_noise_amp_gain <= 3'h0;
      else if (!i_rx_cfg.agc_on)
         o_low_noise_amp_gain <= i_rx_cfg.lna_gain;
   end

   // First strength sample after the evaluation interval past ready
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rssi_cnt_r <= '0;
         rssi_valid_r <= 1'b0;
      end else if (!o_rx_ready) begin
         rssi_cnt_r <= i_signal_strength_eval_delay;
         rssi_valid_r <= 1'b0;
      end else if (rssi_cnt_r != '0) begin
         rssi_cnt_r <= rssi_cnt_r - 16'h1;
      end else begin
         rssi_valid_r <= 1'b1;
      end
   end
   assign o_rssi_valid = rssi_valid_r;

   // Auto restart: wait for FIFO drain after payload, then inter-packet gap
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wait_empty_r <= 1'b0;
         gap_run_r <= 1'b0;
         gap_r <= '0;
      end else if (!is_rx || restart || i_rx_cfg.auto_restart != AUTO_RESTART_SAME) begin
         wait_empty_r <= 1'b0;
         gap_run_r <= 1'b0;
      end else if (payload_ev && !gap_run_r) begin
         wait_empty_r <= 1'b1;
      end else if (wait_empty_r && fifo_empty) begin
         wait_empty_r <= 1'b0;
         gap_run_r <= 1'b1;
         gap_r <= i_inter_packet_cyc;
      end else if (gap_run_r && gap_r != '0) begin
         gap_r <= gap_r - GAP_W'(1);
      end
   end

   assign o_timeout_rssi_en = trig_rssi;
   assign o_timeout_preamble_en = trig_pre;
   assign o_timeout_sync_en = i_rx_cfg.trigger == TRIG_PREAMBLE;
endmodule // tmc_mode_ctrl
`default_nettype wire

// [tb/tmc_mode_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_mode_chk
   import tmc_pkg::*;
(
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   // Watched inputs
   input wire logic [2:0] i_operating_mode_register,
   input wire tmc_pkg::tmc_rx_cfg_t i_rx_cfg,
   input wire logic i_restart_keep_oscillator_wr,
   // Watched outputs
   input wire tmc_pkg::tmc_blocks_t o_blocks,
   input wire logic o_mode_ready_flag,
   input wire logic o_tx_ready,
   input wire logic o_rx_ready,
   input wire logic o_rssi_valid,
   input wire logic o_restart_keep_oscillator,
   input wire logic o_agc_run,
   input wire logic o_afc_run,
   input wire logic [2:0] o_low_noise_amp_gain,
   input wire logic o_timeout_rssi_en,
   input wire logic o_timeout_preamble_en,
   input wire logic o_timeout_sync_en
);
   import tmc_pkg::*;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);
   wire logic [2:0] trg = i_rx_cfg.trigger;
   wire logic [2:0] md = i_operating_mode_register;
   chk_sleep_off: assert property (o_mode_ready_flag && md == MODE_SLEEP |-> o_blocks == BLK_ALL_OFF)
      else $error("blocks powered in sleep");
   chk_synth_order: assert property ($rose(o_blocks.synth) |-> o_blocks.oscillator && o_blocks.regulator)
      else $error("synth woke before oscillator");
   chk_rf_order: assert property ($rose(o_blocks.rf_path) |-> o_blocks.synth)
      else $error("rf path woke before synth");
   chk_ready_drop: assert property ($changed(md) |-> !o_mode_ready_flag)
      else $error("ready held over mode change");
   chk_restart_clear: assert property (o_restart_keep_oscillator && o_mode_ready_flag && md == MODE_RX
      |=> !o_restart_keep_oscillator && !o_mode_ready_flag)
      else $error("restart bit stuck or ready held");
   chk_restart_drop: assert property (i_restart_keep_oscillator_wr && !o_mode_ready_flag
      |-> ##2 !o_restart_keep_oscillator)
      else $error("restart kept while not ready");
   chk_tx_gate: assert property (o_tx_ready |-> md == MODE_TX && o_mode_ready_flag && o_blocks == 4'hf)
      else $error("tx ready out of transmit");
   chk_rx_gate: assert property (o_rx_ready |-> md == MODE_RX && o_blocks.rf_path)
      else $error("rx ready out of receive");
   chk_rssi_late: assert property ($rose(o_rssi_valid) |-> o_rx_ready && $past(o_rx_ready))
      else $error("strength sample before rx ready");
   chk_manual_gain: assert property (o_rx_ready && !i_rx_cfg.agc_on && $stable(i_rx_cfg.lna_gain)
      |-> o_low_noise_amp_gain == i_rx_cfg.lna_gain)
      else $error("manual gain not applied");
   chk_afc_agc: assert property (o_afc_run |-> o_agc_run)
      else $error("frequency correction without gain");
   chk_timeout_map: assert property (o_timeout_rssi_en == (trg == TRIG_RSSI || trg == TRIG_BOTH)
      && o_timeout_preamble_en == (trg[2:1] == 2'h3) && o_timeout_sync_en == (trg == TRIG_PREAMBLE))
      else $error("timeout enables wrong");
   cover property ($rose(o_tx_ready));
   cover property ($rose(o_rx_ready));
   cover property ($rose(o_afc_run));
   cover property ($fell(o_mode_ready_flag) && md == MODE_RX);
endmodule // tmc_mode_chk
`default_nettype wire

// [tb/tmc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_host_model (
   // Host intent
   input wire logic i_req,
   input wire logic i_afc_on,
   input wire logic i_frf_changed,
   // Trigger writes
   output logic o_keep_wr,
   output logic o_relock_wr
);
   // Keeping the oscillator is only safe when nothing moved the carrier
   assign o_keep_wr = i_req && !i_afc_on && !i_frf_changed;
   assign o_relock_wr = i_req && (i_afc_on || i_frf_changed);
endmodule // tmc_host_model
`default_nettype wire

// [tb/tmc_mode_ctrl_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin miscompares++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tmc_mode_ctrl_test;
   import tmc_pkg::*;
   logic i_sys_clk = 0, i_rst_b = 0, ook = 0, req = 0, frf = 0;
   logic rssi_p = 0, pre_p = 0, pay_p = 0, fe_p = 0;
   logic [2:0] mode = MODE_STDBY;
   logic [15:0] ramp = 16'h000a, bitc = 16'h0064;
   tmc_rx_cfg_t cfg = '0;
   wire logic keep_wr, relock_wr;
   tmc_blocks_t blocks;
   logic rdy, txr, rxr, rsv, kb, rb, agc, afc, tr, tp, ts;
   logic [2:0] gain;
   logic [2:0] trg_tab [4] = '{TRIG_NONE, TRIG_RSSI, TRIG_PREAMBLE, TRIG_BOTH};
   logic [2:0] ten_tab [4] = '{3'h0, 3'h4, 3'h3, 3'h6};
   int miscompares = 0, compares = 0, cycles = 0, n, n2, nchg;
   initial forever #12.5 i_sys_clk = ~i_sys_clk;
   tmc_host_model host (.i_req(req), .i_afc_on(cfg.afc_on), .i_frf_changed(frf),
      .o_keep_wr(keep_wr), .o_relock_wr(relock_wr));
   tmc_mode_ctrl #(.RELOCK_CYC(20)) uut (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
      .i_operating_mode_register(mode), .i_ook(ook), .i_amplifier_ramp_time(ramp), .i_bit_cyc(bitc),
      .i_signal_strength_eval_delay(16'h0028), .i_rx_cfg(cfg), .i_inter_packet_cyc(16'h001e),
      .i_restart_keep_oscillator_wr(keep_wr), .i_restart_relock_oscillator_wr(relock_wr),
      .i_rssi_event_pin(rssi_p), .i_preamble_found_flag_pin(pre_p), .i_payload_ready_pin(pay_p),
      .i_fifo_empty_pin(fe_p), .o_blocks(blocks), .o_mode_ready_flag(rdy), .o_tx_ready(txr),
      .o_rx_ready(rxr), .o_rssi_valid(rsv), .o_restart_keep_oscillator(kb),
      .o_restart_relock_oscillator(rb), .o_agc_run(agc), .o_afc_run(afc), .o_low_noise_amp_gain(gain),
      .o_timeout_rssi_en(tr), .o_timeout_preamble_en(tp), .o_timeout_sync_en(ts));
   task complete_run();
      if (miscompares == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         complete_run();
      end
   end
   task tick(input int k);
      repeat (k) @(negedge i_sys_clk);
   endtask
   // Counts wake-up steps too, so the step-count check costs no extra pass
   task wait_rdy();
      tmc_blocks_t prev;
      n = 0;
      nchg = 0;
      prev = blocks;
      while (rdy !== 1'b1 && n < 6000) begin
         tick(1);
         n++;
         if (blocks !== prev) nchg++;
         prev = blocks;
      end
   endtask
   task go(input logic [2:0] m);
      mode = m;
      #1;
      `CHK(rdy, 1'b0)
      wait_rdy();
   endtask
   task restart();
      req = 1;
      tick(1);
      req = 0;
   endtask
   initial begin
      cfg.rx_bw = 5'h14;
      cfg.afc_bw = 5'h14;
      cfg.lna_gain = 3'h5;
      tick(20);
      i_rst_b = 1;
      tick(2);
      go(MODE_TX);
      `CHK(n >= 750 && n <= 790, 1'b1)
      `CHK(txr, 1'b1)
      go(MODE_STDBY);
      ook = 1;
      go(MODE_TX);
      `CHK(n >= 250 && n <= 290, 1'b1)
      go(MODE_SLEEP);
      `CHK(blocks, BLK_ALL_OFF)
      go(MODE_FS_TX);
      `CHK(nchg, 3)
      `CHK(blocks, 4'he)
      go(MODE_STDBY);
      `CHK(blocks, 4'hc)
      go(MODE_FS_RX);
      `CHK(blocks, 4'he)
      cfg.rx_bw = 5'h13;
      go(MODE_RX);
      `CHK(n >= 2960 && n <= 3000, 1'b1)
      `CHK(rxr, 1'b1)
      `CHK(gain, 3'h5)
      n = 0;
      while (rsv !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      `CHK(n >= 40 && n <= 43, 1'b1)
      cfg.rx_bw = 5'h14;
      cfg.agc_on = 1;
      cfg.afc_on = 1;
      cfg.trigger = TRIG_PREAMBLE;
      rssi_p = 1;
      tick(3);
      rssi_p = 0;
      tick(6);
      `CHK(agc, 1'b0)
      pre_p = 1;
      tick(3);
      pre_p = 0;
      tick(6);
      `CHK({agc, afc}, 2'h3)
      for (int i = 0; i < 4; i++) begin
         cfg.trigger = trg_tab[i];
         tick(1);
         `CHK({tr, tp, ts}, ten_tab[i])
      end
      restart();
      `CHK(rb, 1'b1)
      tick(1);
      `CHK({rb, rdy}, 2'h0)
      wait_rdy();
      n2 = n;
      cfg.afc_on = 0;
      restart();
      `CHK(kb, 1'b1)
      tick(1);
      `CHK({kb, rdy}, 2'h0)
      // A second request while not ready must leave no trace
      restart();
      wait_rdy();
      `CHK(n2 - n, 20 - STEP_CYC + 1)
      tick(5);
      `CHK(rdy, 1'b1)
      cfg.auto_restart = AUTO_RESTART_SAME;
      pay_p = 1;
      tick(3);
      pay_p = 0;
      fe_p = 1;
      n = 0;
      while (rdy === 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      `CHK(n >= 30 && n <= 36, 1'b1)
      fe_p = 0;
      cfg.auto_restart = AUTO_RESTART_OFF;
      wait_rdy();
      go(MODE_STDBY);
      restart();
      tick(4);
      `CHK(rdy, 1'b1)
      complete_run();
   end
endmodule // tmc_mode_ctrl_test
bind tmc_mode_ctrl tmc_mode_chk chk_i (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b),
   .i_operating_mode_register(i_operating_mode_register), .i_rx_cfg(i_rx_cfg),
   .i_restart_keep_oscillator_wr(i_restart_keep_oscillator_wr), .o_blocks(o_blocks),
   .o_mode_ready_flag(o_mode_ready_flag), .o_tx_ready(o_tx_ready), .o_rx_ready(o_rx_ready),
   .o_rssi_valid(o_rssi_valid), .o_restart_keep_oscillator(o_restart_keep_oscillator),
   .o_agc_run(o_agc_run), .o_afc_run(o_afc_run), .o_low_noise_amp_gain(o_low_noise_amp_gain),
   .o_timeout_rssi_en(o_timeout_rssi_en), .o_timeout_preamble_en(o_timeout_preamble_en),
   .o_timeout_sync_en(o_timeout_sync_en));
`default_nettype wire
